// [design/xbcfg_params.svh]
`ifndef XBCFG_PARAMS_SVH
`define XBCFG_PARAMS_SVH

// ==========================================================
// Register offsets on the device control register port
// ==========================================================
`define XBCFG_OFS_QERR      10'h029
`define XBCFG_OFS_QRST      10'h02B
`define XBCFG_OFS_TMPL0     10'h02D
`define XBCFG_OFS_TMPL1     10'h02E
`define XBCFG_OFS_TMPL2     10'h02F
`define XBCFG_OFS_TMPL3     10'h030
`define XBCFG_OFS_TSEL      10'h031
`define XBCFG_OFS_S0CFG     10'h034

// ==========================================================
// Field positions, counted from the LSB (printed bit 0 is the MSB)
// ==========================================================
`define XBCFG_QERR_WR_OVF   3
`define XBCFG_QERR_WR_UNF   2
`define XBCFG_QERR_RD_OVF   1
`define XBCFG_QERR_RD_UNF   0
`define XBCFG_QRST_RD       1
`define XBCFG_QRST_WR       0
`define XBCFG_S0_LOCK       31
`define XBCFG_S0_DMA_CHAN1_ENABLE    29
`define XBCFG_S0_DMA_CHAN0_ENABLE    28
`define XBCFG_S0_DMA_CHAN0_PRIORITY   27:26
`define XBCFG_S0_DMA_CHAN1_PRIORITY   25:24
`define XBCFG_S0_RD_MEM     22:20
`define XBCFG_S0_RD_MST     18:16
`define XBCFG_S0_WR_MEM     14:12

// ==========================================================
// Reset values and implemented-bit masks
// ==========================================================
`define XBCFG_QERR_MASK     32'h0000_000F
`define XBCFG_S0_MASK       32'hBF77_7000
`define XBCFG_S0_RESET      32'h8033_3000
`define XBCFG_TMPL0_RESET   32'hFFFF_0000
`define XBCFG_TMPLN_RESET   32'h0000_0000
`define XBCFG_TSEL_RESET    32'h3FFF_FFFF

`endif

// [design/xbcfg_pkg.sv]
package xbcfg_pkg;

    // ======================================================
    // Shared types
    // ======================================================
    typedef logic [31:0] xbcfg_word_t;

    // Queue error events, one-cycle pulses from the memory side
    typedef struct packed {
        logic wr_ovf;
        logic wr_unf;
        logic rd_ovf;
        logic rd_unf;
    } xbcfg_qerr_s;

    // Decoded slave 0 configuration
    typedef struct packed {
        logic       error_capture_lock;
        logic       dma_chan0_enable;
        logic       dma_chan1_enable;
        logic [1:0] dma_chan0_priority;
        logic [1:0] dma_chan1_priority;
        logic [4:0] read_mem_burst;
        logic [4:0] read_master_burst;
        logic [4:0] write_mem_burst;
    } xbcfg_s0_s;

    // Routing answer for one transaction
    typedef struct packed {
        logic       valid;
        logic       to_mem;
        logic [1:0] tmpl_idx;
    } xbcfg_route_s;

endpackage

// [design/xbcfg_top.sv]
`timescale 1ns/1ps
`include "xbcfg_params.svh"

// Functional notes
// - Queue error flags sticky, write-one clears
// - Any queue error raises interrupt status flag
// - Error flag positions at bits 28 to 31
// - Writing bits 30/31 flushes read/write queues
// - Write-only flush bits read back zero
// - Four 32-bit templates, 128 MB per bit
// - Set bit routes to memory, else master
// - Template reset values FFFF_0000 and zero
// - Templates loaded from init attributes
// - Sixteen 2-bit selectors, one per segment
// - Selector resets to 3FFF_FFFF
// - Lock bit freezes error capture, resets one
// - DMA enables and priorities, reset zero
// - Thresholds 000..100 give bursts 1..16
// - Read memory threshold bits 9:11, reset 011
// - Read master threshold bits 13:15, reset 011
// - Write memory threshold bits 17:19, reset 011
// - Slave 0 configuration loaded from attribute
module xbcfg_top #(
    parameter logic [31:0] TMPL0_INIT = `XBCFG_TMPL0_RESET,
    parameter logic [31:0] TMPL1_INIT = `XBCFG_TMPLN_RESET,
    parameter logic [31:0] TMPL2_INIT = `XBCFG_TMPLN_RESET,
    parameter logic [31:0] TMPL3_INIT = `XBCFG_TMPLN_RESET,
    parameter logic [31:0] S0_INIT    = `XBCFG_S0_RESET
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  dcr_cs,
    input  wire logic                  dcr_we,
    input  wire logic [9:0]            dcr_addr,
    input  wire xbcfg_pkg::xbcfg_word_t dcr_wdata,
    output xbcfg_pkg::xbcfg_word_t     dcr_rdata,
    output logic                       dcr_ack,
    input  wire xbcfg_pkg::xbcfg_qerr_s qerr_evt,
    output logic                       xbar_irq_qerr,
    output logic                       read_queue_flush,
    output logic                       write_queue_flush,
    input  wire logic                  xact_valid,
    input  wire logic [35:0]           xact_addr,
    output xbcfg_pkg::xbcfg_route_s    route,
    output xbcfg_pkg::xbcfg_s0_s       s0_cfg
);
    import xbcfg_pkg::*;

    // ======================================================
    // Storage
    // ======================================================
    logic [3:0]   qerr_q;          // Sticky queue error flags
    logic [31:0]  tmpl_q [4];      // Routing templates
    logic [31:0]  tsel_q;          // Segment template selector
    logic [31:0]  s0_q;            // Slave 0 configuration
    logic         rflush_q;        // Read queue flush pulse
    logic         wflush_q;        // Write queue flush pulse
    xbcfg_word_t  rdata_q;         // Read data holding register
    logic         ack_q;           // Access acknowledge
    xbcfg_route_s route_q;         // Registered routing answer
    logic         wr_en;           // Register write this cycle
    logic [3:0]   qerr_clr;        // W1C clear vector
    logic [1:0]   seg_sel;         // Template chosen for segment
    logic [4:0]   region;          // 128 MB region within segment
    logic [31:0]  rd_mux;          // Combinational read value

    // Every selected cycle with write set is a write; no wait states exist
    assign wr_en = dcr_cs && dcr_we;

    // Turns a 3-bit translation code into a burst length.
    // Reserved codes fall back to single transfers so nothing odd escapes.
    function automatic logic [4:0] thr_len(input logic [2:0] code);
        logic [4:0] len;
        len = 5'h01;
        if (code <= 3'h4) begin
            len = 5'(5'h01 << code);
        end
        return len;
    endfunction

    // ======================================================
    // Queue error flags
    // ======================================================
    // A flag set in the same cycle as its clear survives
    assign qerr_clr = (wr_en && dcr_addr == `XBCFG_OFS_QERR) ?
                      dcr_wdata[3:0] : 4'h0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            qerr_q <= 4'h0;
        end else begin
            qerr_q <= (qerr_q & ~qerr_clr) | qerr_evt;
        end
    end

    // Crossbar interrupt status flag follows any set error bit
    assign xbar_irq_qerr = |qerr_q;

    // ======================================================
    // Queue flush controls
    // ======================================================
    // One-cycle pulses; nothing is stored, so reads see zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rflush_q <= 1'b0;
            wflush_q <= 1'b0;
        end else begin
            rflush_q <= wr_en && dcr_addr == `XBCFG_OFS_QRST &&
                        dcr_wdata[`XBCFG_QRST_RD];
            wflush_q <= wr_en && dcr_addr == `XBCFG_OFS_QRST &&
                        dcr_wdata[`XBCFG_QRST_WR];
        end
    end

    assign read_queue_flush  = rflush_q;
    assign write_queue_flush = wflush_q;

    // ======================================================
    // Templates and selector
    // ======================================================
    // Reset loads the init attributes, whose defaults are the documented values
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tmpl_q[0] <= TMPL0_INIT;
            tmpl_q[1] <= TMPL1_INIT;
            tmpl_q[2] <= TMPL2_INIT;
            tmpl_q[3] <= TMPL3_INIT;
        end else if (wr_en && dcr_addr >= `XBCFG_OFS_TMPL0 &&
                     dcr_addr <= `XBCFG_OFS_TMPL3) begin
            tmpl_q[2'(dcr_addr - `XBCFG_OFS_TMPL0)] <= dcr_wdata;
        end
    end

    // Selector: sixteen 2-bit fields, segment 0 in the top pair
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tsel_q <= `XBCFG_TSEL_RESET;
        end else if (wr_en && dcr_addr == `XBCFG_OFS_TSEL) begin
            tsel_q <= dcr_wdata;
        end
    end

    // ======================================================
    // Slave 0 configuration
    // ======================================================
    // Unimplemented bits are masked so they always read zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s0_q <= S0_INIT & `XBCFG_S0_MASK;
        end else if (wr_en && dcr_addr == `XBCFG_OFS_S0CFG) begin
            s0_q <= dcr_wdata & `XBCFG_S0_MASK;
        end
    end

    // Decoded view for the slave; burst lengths come from the codes
    always_comb begin
        s0_cfg.error_capture_lock = s0_q[`XBCFG_S0_LOCK];
        s0_cfg.dma_chan0_enable   = s0_q[`XBCFG_S0_DMA_CHAN0_ENABLE];
        s0_cfg.dma_chan1_enable   = s0_q[`XBCFG_S0_DMA_CHAN1_ENABLE];
        s0_cfg.dma_chan0_priority = s0_q[`XBCFG_S0_DMA_CHAN0_PRIORITY];
        s0_cfg.dma_chan1_priority = s0_q[`XBCFG_S0_DMA_CHAN1_PRIORITY];
        s0_cfg.read_mem_burst     = thr_len(s0_q[`XBCFG_S0_RD_MEM]);
        s0_cfg.read_master_burst  = thr_len(s0_q[`XBCFG_S0_RD_MST]);
        s0_cfg.write_mem_burst    = thr_len(s0_q[`XBCFG_S0_WR_MEM]);
    end

    // ======================================================
    // Address routing
    // ======================================================
    // Segment k owns selector bits [31-2k -: 2], printed bit 0 first
    assign seg_sel = tsel_q[5'(31 - 2 * xact_addr[35:32]) -: 2];
    assign region  = xact_addr[31:27];

    // Registered so the answer comes from flip-flops, one cycle late
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            route_q <= '0;
        end else begin
            route_q.valid    <= xact_valid;
            route_q.tmpl_idx <= seg_sel;
            route_q.to_mem   <= tmpl_q[seg_sel][5'd31 - region];
        end
    end

    assign route = route_q;

    // ======================================================
    // Register read port
    // ======================================================
    // Read mux: reserved and write-only places return zero
    always_comb begin
        case (dcr_addr)
            `XBCFG_OFS_QERR:  rd_mux = {28'h000_0000, qerr_q};
            `XBCFG_OFS_QRST:  rd_mux = 32'h0000_0000;
            `XBCFG_OFS_TMPL0: rd_mux = tmpl_q[0];
            `XBCFG_OFS_TMPL1: rd_mux = tmpl_q[1];
            `XBCFG_OFS_TMPL2: rd_mux = tmpl_q[2];
            `XBCFG_OFS_TMPL3: rd_mux = tmpl_q[3];
            `XBCFG_OFS_TSEL:  rd_mux = tsel_q;
            `XBCFG_OFS_S0CFG: rd_mux = s0_q;
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    // Every select is acknowledged; unmapped reads return zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
            ack_q   <= 1'b0;
        end else begin
            ack_q <= dcr_cs;
            if (dcr_cs && !dcr_we) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign dcr_rdata = rdata_q;
    assign dcr_ack   = ack_q;

    // ======================================================
    // Assertions
    // ======================================================
    // Independent view of the lookup: shifts instead of part-selects, so a
    // slip in the datapath index does not hide behind the same expression
    logic [1:0]  chk_sel;         // Template the selector names for the segment
    logic [31:0] chk_map;         // Chosen template with the region bit on top
    logic [31:0] chk_wd_q;        // Write data of the previous cycle
    assign chk_sel = 2'(tsel_q >> (5'd30 - {xact_addr[35:32], 1'b0}));
    assign chk_map = tmpl_q[chk_sel] << xact_addr[31:27];

    // Write data one cycle back, so a write's effect is checked next cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chk_wd_q <= '0;
        end else begin
            chk_wd_q <= dcr_wdata;
        end
    end

    // Queue error flags and the interrupt status they feed

    AST_QERR_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
        qerr_q[3] && !qerr_clr[3] |=> qerr_q[3])
        else $error("queue error flag dropped without clear");

    AST_QERR_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        qerr_clr[0] && !qerr_evt[0] |=> !qerr_q[0])
        else $error("queue error flag not cleared");

    AST_QERR_SET: assert property (@(posedge clk) disable iff (!rst_n)
        qerr_evt.wr_ovf |=> qerr_q[`XBCFG_QERR_WR_OVF])
        else $error("write overflow not flagged at its bit");

    AST_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
        qerr_evt != 4'h0 |=> xbar_irq_qerr)
        else $error("interrupt flag missing on queue error");

    // An event landing with its own clear must still leave the flag set
    AST_QERR_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
        qerr_evt.rd_ovf && qerr_clr[1] |=> qerr_q[1])
        else $error("queue error event lost to a same-cycle clear");

    // Flush pulses: one per write with the bit set, never otherwise
    AST_FLUSH: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && dcr_addr == `XBCFG_OFS_QRST && dcr_wdata[`XBCFG_QRST_RD]
        |=> read_queue_flush)
        else $error("read queue flush pulse missing");

    AST_FLUSH_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        !(wr_en && dcr_addr == `XBCFG_OFS_QRST && dcr_wdata[`XBCFG_QRST_RD])
        |=> !read_queue_flush)
        else $error("read queue flush without a write");

    AST_WFLUSH: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && dcr_addr == `XBCFG_OFS_QRST |=> write_queue_flush == chk_wd_q[0])
        else $error("write queue flush does not follow the written bit");

    AST_WO_READ: assert property (@(posedge clk) disable iff (!rst_n)
        dcr_cs && !dcr_we && dcr_addr == `XBCFG_OFS_QRST |=> dcr_ack && dcr_rdata == 0)
        else $error("write-only register read nonzero");

    // Routing answer one cycle after the lookup
    AST_ROUTE: assert property (@(posedge clk) disable iff (!rst_n)
        xact_valid |=> route.valid && route.to_mem == $past(chk_map[31]))
        else $error("route decision does not follow template");

    AST_ROUTE_SEL: assert property (@(posedge clk) disable iff (!rst_n)
        xact_valid |=> route.tmpl_idx == $past(chk_sel))
        else $error("route used the wrong template");

    AST_TMPL_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && dcr_addr == `XBCFG_OFS_TMPL2 |=> tmpl_q[2] == chk_wd_q)
        else $error("template write did not land");

    AST_RESERVED: assert property (@(posedge clk) disable iff (!rst_n)
        (s0_q & ~`XBCFG_S0_MASK) == 0)
        else $error("reserved slave 0 bit set");

    AST_THR: assert property (@(posedge clk) disable iff (!rst_n)
        s0_q[`XBCFG_S0_RD_MEM] == 3'h3 |-> s0_cfg.read_mem_burst == 5'h08)
        else $error("threshold 011 does not give burst of 8");

    // A slave 0 write shows in the decoded view one cycle later
    AST_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && dcr_addr == `XBCFG_OFS_S0CFG |=> s0_cfg.error_capture_lock == chk_wd_q[31])
        else $error("error capture lock does not follow the write");

    AST_DMA_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && dcr_addr == `XBCFG_OFS_S0CFG |=>
        {s0_cfg.dma_chan0_enable, s0_cfg.dma_chan1_enable, s0_cfg.dma_chan0_priority,
         s0_cfg.dma_chan1_priority} == {chk_wd_q[28], chk_wd_q[29], chk_wd_q[27:24]})
        else $error("dma enable or priority does not follow the write");

    // Reserved codes are the writer's fault, so only legal codes are checked
    AST_THR_MST: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && dcr_addr == `XBCFG_OFS_S0CFG && dcr_wdata[18:16] <= 3'h4 |=>
        s0_cfg.read_master_burst == 5'(5'h01 << chk_wd_q[18:16]))
        else $error("read master threshold gives the wrong burst");

    AST_THR_WR: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && dcr_addr == `XBCFG_OFS_S0CFG && dcr_wdata[14:12] <= 3'h4 |=>
        s0_cfg.write_mem_burst == 5'(5'h01 << chk_wd_q[14:12]))
        else $error("write memory threshold gives the wrong burst");

    // ======================================================
    // Cover points
    // ======================================================
    COV_QERR_CLR: cover property (@(posedge clk) disable iff (!rst_n)
        qerr_q[0] ##1 qerr_clr[0] ##1 !qerr_q[0]);
    COV_SET_CLEAR_SAME: cover property (@(posedge clk) disable iff (!rst_n)
        qerr_evt[1] && qerr_clr[1]);
    COV_ROUTE_MEM: cover property (@(posedge clk) disable iff (!rst_n)
        route.valid && route.to_mem);
    COV_HIGH_SEG: cover property (@(posedge clk) disable iff (!rst_n)
        xact_valid && xact_addr[35:32] != 4'h0);
    COV_BOTH_FLUSH: cover property (@(posedge clk) disable iff (!rst_n)
        read_queue_flush && write_queue_flush);

endmodule // xbcfg_top

// [sim/xbcfg_qside.sv]
`timescale 1ns/1ps
// ==================================================
// Memory-side queue model: raises error events, counts flushes
// ==================================================
module xbcfg_qside (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire xbcfg_pkg::xbcfg_qerr_s fire,
    input  wire logic                   rd_flush,
    input  wire logic                   wr_flush,
    output xbcfg_pkg::xbcfg_qerr_s      qerr_evt,
    output int                          rd_n,
    output int                          wr_n
);
    import xbcfg_pkg::*;

    // Registered so each request reaches the crossbar one cycle later, held for as long as fire is
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            qerr_evt <= '0;
        end else begin
            qerr_evt <= fire;
        end
    end

    // Each pulse empties one queue; counts let the bench see every pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_n <= 0;
            wr_n <= 0;
        end else begin
            rd_n <= rd_n + int'(rd_flush);
            wr_n <= wr_n + int'(wr_flush);
        end
    end
endmodule // xbcfg_qside

// [sim/xbcfg_top_bench.sv]
`timescale 1ns/1ps
// ==================================================
// Self-checking bench with a reference register model
// ==================================================
module xbcfg_top_bench;
    import xbcfg_pkg::*;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         cs = 1'b0;
    logic         we = 1'b0;
    logic [9:0]   ad = '0;
    xbcfg_word_t  wd = '0;
    xbcfg_word_t  rdat;
    logic         ack, irq, rqf, wqf;
    logic         xv = 1'b0;
    logic [35:0]  xa = '0;
    xbcfg_qerr_s  fire = '0;
    xbcfg_qerr_s  evt;
    xbcfg_route_s route;
    xbcfg_s0_s    s0_cfg;
    int           rd_n, wr_n, ef_r, ef_w;
    int           failures = 0;
    int           n_checks = 0;
    int           cycles = 0;
    integer       seed = 32'hea64489e;
    // Reference model state
    logic [31:0]  tm [4];
    logic [31:0]  ts, s0, v;
    logic [3:0]   fl;
    // Mapped places plus two unmapped ones
    logic [9:0]   regs [10] = '{10'h029, 10'h02B, 10'h02D, 10'h02E, 10'h02F,
                                10'h030, 10'h031, 10'h034, 10'h000, 10'h3FF};

    always #25 clk = ~clk;

    xbcfg_top dut (.clk(clk), .rst_n(rst_n), .dcr_cs(cs), .dcr_we(we), .dcr_addr(ad),
        .dcr_wdata(wd), .dcr_rdata(rdat), .dcr_ack(ack), .qerr_evt(evt),
        .xbar_irq_qerr(irq), .read_queue_flush(rqf), .write_queue_flush(wqf),
        .xact_valid(xv), .xact_addr(xa), .route(route), .s0_cfg(s0_cfg));
    xbcfg_qside far (.clk(clk), .rst_n(rst_n), .fire(fire), .rd_flush(rqf),
        .wr_flush(wqf), .qerr_evt(evt), .rd_n(rd_n), .wr_n(wr_n));

    // ==================================================
    // Checking helpers
    // ==================================================
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Read-back value the model predicts for one place
    function automatic logic [31:0] rexp(input logic [9:0] a);
        case (a)
            10'h029: return {28'h000_0000, fl};
            10'h02D, 10'h02E, 10'h02F, 10'h030: return tm[a - 10'h02D];
            10'h031: return ts;
            10'h034: return s0;
            default: return 32'h0000_0000;
        endcase
    endfunction

    // One register access; the flush pulses show in the ack cycle only
    task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d);
        logic [31:0] e;
        e = rexp(a);
        cs <= 1'b1;
        we <= w;
        ad <= a;
        wd <= d;
        @(posedge clk);
        cs <= 1'b0;
        #1;
        chk("ack", 32'h0000_0001, 32'(ack));
        if (!w) chk("rdata", e, rdat);
        chk("rd flush", 32'(w && a == 10'h02B && d[1]), 32'(rqf));
        chk("wr flush", 32'(w && a == 10'h02B && d[0]), 32'(wqf));
        if (w) begin
            if (a == 10'h029) fl = fl & ~d[3:0];
            if (a >= 10'h02D && a <= 10'h030) tm[a - 10'h02D] = d;
            if (a == 10'h031) ts = d;
            if (a == 10'h034) s0 = d & 32'hBF77_7000;
            if (a == 10'h02B) begin
                ef_r += int'(d[1]);
                ef_w += int'(d[0]);
            end
        end
        @(posedge clk);
    endtask

    // Slave 0 decode worked out from the model word
    task automatic chk_cfg;
        xbcfg_s0_s e;
        e.error_capture_lock = s0[31];
        e.dma_chan0_enable = s0[28];
        e.dma_chan1_enable = s0[29];
        e.dma_chan0_priority = s0[27:26];
        e.dma_chan1_priority = s0[25:24];
        e.read_mem_burst = 5'(1 << s0[22:20]);
        e.read_master_burst = 5'(1 << s0[18:16]);
        e.write_mem_burst = 5'(1 << s0[14:12]);
        chk("s0_cfg", 32'(e), 32'(s0_cfg));
    endtask

    // One routing lookup, answered one edge later
    task automatic rt(input logic [35:0] a);
        logic [1:0] i;
        i = ts[31 - 2 * a[35:32] -: 2];
        xv <= 1'b1;
        xa <= a;
        @(posedge clk);
        xv <= 1'b0;
        #1;
        chk("route", {28'h000_0000, 1'b1, tm[i][31 - a[31:27]], i}, 32'(route));
        @(posedge clk);
    endtask

    // Draw a config word with legal threshold codes only
    task automatic s0_word;
        v = $random(seed);
        v[22:20] = 3'({$random(seed)} % 5);
        v[18:16] = 3'({$random(seed)} % 5);
        v[14:12] = 3'({$random(seed)} % 5);
    endtask

    // Model state right after any reset, from the init attribute defaults
    task automatic mdl_reset;
        tm = '{32'hFFFF_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
        ts = 32'h3FFF_FFFF;
        s0 = 32'h8033_3000;
        fl = 4'h0;
        ef_r = 0;
        ef_w = 0;
    endtask

    task automatic test_done;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Cuts a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            test_done;
        end
    end

    // ==================================================
    // Main sequence
    // ==================================================
    initial begin
        mdl_reset;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (regs[k]) acc(1'b0, regs[k], 32'h0000_0000);
        chk_cfg;
        rt(36'h0_0000_0000);
        rt(36'h0_F800_0000);
        rt(36'h5_0800_0000);
        $display("reset test done");
        // Random writes everywhere, then read back and route through them
        repeat (8) begin
            foreach (regs[k]) begin
                v = $random(seed);
                if (regs[k] == 10'h034) s0_word;
                acc(1'b1, regs[k], v);
                acc(1'b0, regs[k], 32'h0000_0000);
            end
            chk_cfg;
            repeat (4) rt({4'($random(seed)), 32'($random(seed))});
        end
        $display("register and routing test done");
        // Reset in mid-run must bring every place back; flush counts restart
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        mdl_reset;
        @(posedge clk);
        foreach (regs[k]) acc(1'b0, regs[k], 32'h0000_0000);
        chk_cfg;
        $display("mid-run reset test done");
        // Every legal threshold code, 000..100, in every field
        for (int c = 0; c < 5; c++) begin
            s0_word;
            v[22:20] = 3'(c);
            v[18:16] = 3'(c);
            v[14:12] = 3'(c);
            acc(1'b1, 10'h034, v);
            chk_cfg;
        end
        $display("threshold test done");
        // Queue errors: set one by one, then clear one by one
        chk("irq", 32'h0000_0000, 32'(irq));
        for (int i = 0; i < 4; i++) begin
            fire <= xbcfg_qerr_s'(4'h1 << i);
            @(posedge clk);
            fire <= '0;
            repeat (2) @(posedge clk);
            fl = fl | (4'h1 << i);
            #1;
            chk("irq", 32'h0000_0001, 32'(irq));
            @(posedge clk);
            acc(1'b0, 10'h029, 32'h0000_0000);
        end
        // Event and clear in one cycle: the event wins and the flag stays
        fire <= xbcfg_qerr_s'(4'h2);
        @(posedge clk);
        fire <= '0;
        acc(1'b1, 10'h029, 32'h0000_0002);
        fl = fl | 4'h2;
        acc(1'b0, 10'h029, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, 10'h029, 32'hFFFF_FFF0 | (32'h1 << i));
            acc(1'b0, 10'h029, 32'h0000_0000);
            chk("irq", 32'(|fl), 32'(irq));
        end
        $display("queue error test done");
        chk("rd flushes", 32'(ef_r), 32'(rd_n));
        chk("wr flushes", 32'(ef_w), 32'(wr_n));
        test_done;
    end
endmodule // xbcfg_top_bench
